// ### verilog/frpwm_top.sv
// Fine resolution PWM timer channel with classic Wishbone register slave
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
module frpwm_top
  import frpwm_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // External count event, used when the internal source is not selected
  input wire logic EXT_COUNT_EVENT,
  // Shared pin
  input wire logic PWM_PIN_I,
  output logic PWM_PIN_O,
  output logic PWM_PIN_OE_N
);

  frpwm_state_t q;
  frpwm_state_t n;

  logic req;
  logic wr;
  logic [6:0] div_term;
  logic [6:0] half_term;
  logic presc_tick;
  logic half_tick;
  logic ext_rise;
  logic tick;
  logic [15:0] d_hi;
  logic [15:0] p_hi;
  logic [15:0] cnt_n;
  logic wrap;
  logic start;
  logic pwm_lvl;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge16

  assign WB_DAT_O = q.dat;
  assign WB_ACK_O = q.ack;
  assign PWM_PIN_O = q.pin_o;
  assign PWM_PIN_OE_N = q.pin_oe_n;

  always_comb begin
    n = q;
    req = WB_CYC_I && WB_STB_I && !q.ack;
    wr = req && WB_WE_I;
    // Divide by 2**sel; sel 0 passes the source clock straight through
    div_term = 7'((8'h01 << q.presc_sel) - 8'h01);
    half_term = 7'((8'h01 << q.presc_sel) >> 1);
    presc_tick = q.presc_on && (q.pcnt == div_term);
    // With divide-by-one there is no mid point, so half steps fall on the tick
    half_tick = q.presc_on && q.src_int && (q.presc_sel != FRPWM_SEL_RESET) && (q.pcnt + FRPWM_PCNT_ONE == half_term);
    ext_rise = EXT_COUNT_EVENT && !q.evt_q;
    tick = q.run && (q.src_int ? presc_tick : ext_rise);
    // Fine mode: upper bits count timer clocks, bit 0 adds half a clock
    d_hi = q.fine ? {1'b0, q.duty_act[15:1]} : q.duty_act;
    p_hi = q.fine ? {1'b0, q.period[15:1]} : q.period;
    wrap = q.cnt == p_hi;
    cnt_n = wrap ? FRPWM_CMP_RESET : q.cnt + FRPWM_CNT_ONE;
    start = wr && (WB_ADR_I == FRPWM_MODE_ADDR) && WB_SEL_I[0] && WB_DAT_I[FRPWM_MODE_RUN_BIT] && !q.run;

    n.evt_q = EXT_COUNT_EVENT;
    n.ack = req;
    n.dat = 32'h0000_0000;

    // Prescaler runs only while the timer runs and the clock is on
    if (q.run && q.presc_on && !presc_tick) begin
      n.pcnt = q.pcnt + FRPWM_PCNT_ONE;
    end else begin
      n.pcnt = 7'h00;
    end

    // Half-period edges held over from the last tick
    if (half_tick && q.rise_pend) begin
      n.pwm = 1'b1;
      n.rise_pend = 1'b0;
    end
    if (half_tick && q.fall_pend) begin
      n.pwm = 1'b0;
      n.fall_pend = 1'b0;
    end

    if (tick) begin
      n.cnt = cnt_n;
      if (wrap) begin
        n.duty_act = q.duty_buf;
      end
      if (cnt_n == d_hi) begin
        if (q.fine && q.duty_act[0]) begin
          n.rise_pend = 1'b1;
        end else begin
          n.pwm = 1'b1;
        end
      end
      if (cnt_n == p_hi) begin
        if (q.fine && q.period[0]) begin
          n.fall_pend = 1'b1;
        end else begin
          n.pwm = 1'b0;
        end
      end
      if (!q.fine || !q.presc_on || q.presc_sel == FRPWM_SEL_RESET) begin
        // No mid point available; pending half edges resolve now
        if (n.rise_pend) begin
          n.pwm = 1'b1;
          n.rise_pend = 1'b0;
        end
        if (n.fall_pend) begin
          n.pwm = 1'b0;
          n.fall_pend = 1'b0;
        end
      end
    end

    // Register reads
    if (req && !WB_WE_I) begin
      unique case (WB_ADR_I)
        FRPWM_PRESC_ADDR: begin
          n.dat[FRPWM_PRESC_SEL_LSB +: 3] = q.presc_sel;
          n.dat[FRPWM_PRESC_ON_BIT] = q.presc_on;
        end
        FRPWM_PORT_ADDR: begin
          n.dat[FRPWM_PORT_TIMER_BIT] = q.pin_sel;
          n.dat[FRPWM_PORT_GPIO_DAT_BIT] = q.gpio_dat;
          n.dat[FRPWM_PORT_GPIO_DIR_BIT] = q.gpio_dir;
        end
        FRPWM_DUTY_ADDR: n.dat[15:0] = q.duty_buf;
        FRPWM_PERIOD_ADDR: n.dat[15:0] = q.period;
        FRPWM_MODE_ADDR: begin
          n.dat[FRPWM_MODE_RUN_BIT] = q.run;
          n.dat[FRPWM_MODE_OUTEN_BIT] = q.outen;
          n.dat[FRPWM_MODE_SRC_BIT] = q.src_int;
          n.dat[FRPWM_MODE_INV_BIT] = q.inv;
          n.dat[FRPWM_MODE_BUFEN_BIT] = q.bufen;
          n.dat[FRPWM_MODE_FINE_BIT] = q.fine;
        end
        FRPWM_STATUS_ADDR: begin
          n.dat[15:0] = q.cnt;
          n.dat[FRPWM_STAT_PWM_BIT] = q.pwm;
          n.dat[FRPWM_STAT_PIN_BIT] = PWM_PIN_I;
        end
        default: n.dat = 32'h0000_0000;
      endcase
    end

    // Register writes; software writes win over the counter in the same cycle
    if (wr) begin
      unique case (WB_ADR_I)
        FRPWM_PRESC_ADDR: begin
          if (WB_SEL_I[0]) begin
            n.presc_sel = WB_DAT_I[FRPWM_PRESC_SEL_LSB +: 3];
            n.presc_on = WB_DAT_I[FRPWM_PRESC_ON_BIT];
          end
        end
        FRPWM_PORT_ADDR: begin
          if (WB_SEL_I[0]) begin
            n.pin_sel = WB_DAT_I[FRPWM_PORT_TIMER_BIT];
            n.gpio_dat = WB_DAT_I[FRPWM_PORT_GPIO_DAT_BIT];
            n.gpio_dir = WB_DAT_I[FRPWM_PORT_GPIO_DIR_BIT];
          end
        end
        FRPWM_DUTY_ADDR: begin
          n.duty_buf = merge16(q.duty_buf, WB_DAT_I, WB_SEL_I);
          if (!q.bufen) begin
            n.duty_act = merge16(q.duty_buf, WB_DAT_I, WB_SEL_I);
          end
        end
        FRPWM_PERIOD_ADDR: n.period = merge16(q.period, WB_DAT_I, WB_SEL_I);
        FRPWM_MODE_ADDR: begin
          if (WB_SEL_I[0]) begin
            n.run = WB_DAT_I[FRPWM_MODE_RUN_BIT];
            n.outen = WB_DAT_I[FRPWM_MODE_OUTEN_BIT];
            n.src_int = WB_DAT_I[FRPWM_MODE_SRC_BIT];
            n.inv = WB_DAT_I[FRPWM_MODE_INV_BIT];
            n.bufen = WB_DAT_I[FRPWM_MODE_BUFEN_BIT];
            n.fine = WB_DAT_I[FRPWM_MODE_FINE_BIT];
            // Preset is a strobe and reads back as zero
            if (WB_DAT_I[FRPWM_MODE_PRESET_BIT] || start) begin
              n.cnt = FRPWM_CMP_RESET;
              n.pcnt = 7'h00;
              n.pwm = 1'b0;
              n.rise_pend = 1'b0;
              n.fall_pend = 1'b0;
            end
            if (start) begin
              n.duty_act = q.duty_buf;
            end
          end
        end
        default: n.ack = req;
      endcase
    end

    // Pin drive; idle level keeps the selected polarity
    pwm_lvl = (n.outen ? n.pwm : 1'b0) ^ n.inv;
    if (n.pin_sel) begin
      n.pin_o = pwm_lvl;
      n.pin_oe_n = 1'b0;
    end else begin
      n.pin_o = n.gpio_dat;
      n.pin_oe_n = !n.gpio_dir;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      q <= '0;
      q.pin_oe_n <= 1'b1;
      q.src_int <= 1'b1;
    end else begin
      q <= n;
    end
  end

endmodule : frpwm_top

// ### verilog/frpwm_pkg.sv
// Package of constants and state type for the fine resolution PWM timer
package frpwm_pkg;
  // Register byte addresses
  localparam logic [7:0] FRPWM_PRESC_ADDR = 8'h00;
  localparam logic [7:0] FRPWM_PORT_ADDR = 8'h04;
  localparam logic [7:0] FRPWM_DUTY_ADDR = 8'h08;
  localparam logic [7:0] FRPWM_PERIOD_ADDR = 8'h0c;
  localparam logic [7:0] FRPWM_MODE_ADDR = 8'h10;
  localparam logic [7:0] FRPWM_STATUS_ADDR = 8'h14;
  // Prescaler control fields
  localparam int FRPWM_PRESC_SEL_LSB = 0;
  localparam int FRPWM_PRESC_ON_BIT = 3;
  // Port function config fields
  localparam int FRPWM_PORT_TIMER_BIT = 0;
  localparam int FRPWM_PORT_GPIO_DAT_BIT = 1;
  localparam int FRPWM_PORT_GPIO_DIR_BIT = 2;
  // Mode control fields
  localparam int FRPWM_MODE_RUN_BIT = 0;
  localparam int FRPWM_MODE_PRESET_BIT = 1;
  localparam int FRPWM_MODE_OUTEN_BIT = 2;
  localparam int FRPWM_MODE_SRC_BIT = 3;
  localparam int FRPWM_MODE_INV_BIT = 4;
  localparam int FRPWM_MODE_BUFEN_BIT = 5;
  localparam int FRPWM_MODE_FINE_BIT = 6;
  // Status fields
  localparam int FRPWM_STAT_PWM_BIT = 16;
  localparam int FRPWM_STAT_PIN_BIT = 17;
  // Reset values and counter increments
  localparam logic [15:0] FRPWM_CMP_RESET = 16'h0000;
  localparam logic [2:0] FRPWM_SEL_RESET = 3'h0;
  localparam logic [6:0] FRPWM_PCNT_ONE = 7'h01;
  localparam logic [15:0] FRPWM_CNT_ONE = 16'h0001;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic presc_on;
    logic [2:0] presc_sel;
    logic pin_sel;
    logic gpio_dat;
    logic gpio_dir;
    logic [15:0] duty_buf;
    logic [15:0] duty_act;
    logic [15:0] period;
    logic fine;
    logic bufen;
    logic inv;
    logic src_int;
    logic outen;
    logic run;
    logic [15:0] cnt;
    logic [6:0] pcnt;
    logic pwm;
    logic rise_pend;
    logic fall_pend;
    logic evt_q;
    logic pin_o;
    logic pin_oe_n;
  } frpwm_state_t;
endpackage : frpwm_pkg

// ### test/frpwm_chk.sv
// Port assertions for the fine resolution PWM timer
`timescale 1ns/100ps
module frpwm_chk (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // Pin
  input wire logic PWM_PIN_O,
  input wire logic PWM_PIN_OE_N
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  AST_ACK_NEXT: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("ack missing");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  AST_ACK_QUIET: assert property ((!WB_CYC_I || !WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without request");
  AST_ACK_CAUSE: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack rose without cause");
  AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
    else $error("read data outside ack");
  AST_RST_PIN: assert property ($fell(RST) |-> PWM_PIN_OE_N && !PWM_PIN_O)
    else $error("pin not released by reset");
  // Pin direction only moves through a register write
  AST_OE_CAUSE: assert property ($changed(PWM_PIN_OE_N) |-> WB_ACK_O || $past(WB_ACK_O) || $past(WB_ACK_O, 2))
    else $error("pin direction moved alone");
  AST_GPIO_PIN: assert property (($changed(PWM_PIN_O) && PWM_PIN_OE_N && $past(PWM_PIN_OE_N)) |->
    (WB_ACK_O || $past(WB_ACK_O) || $past(WB_ACK_O, 2)))
    else $error("undriven pin moved alone");
endmodule : frpwm_chk
bind frpwm_top frpwm_chk chk_u (.MCLK(MCLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PWM_PIN_O(PWM_PIN_O), .PWM_PIN_OE_N(PWM_PIN_OE_N));

// ### test/frpwm_tb.sv
// Self-checking bench for the fine resolution PWM timer
`timescale 1ns/100ps
module tb;
  import frpwm_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, ext_evt = 1'b0, ext_pin = 1'b0, watch = 1'b0, prev = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0, lanes = 4'hF;
  logic [31:0] wb_wdat = 32'h0000_0000;
  wire logic [31:0] rdat;
  wire logic ack, pin_o, pin_oe_n, pin_lvl;
  int miscompares = 0, comparisons = 0, ticks = 0, base = 0, per, dty, dty2, inv, fine, len;
  logic [31:0] rd_q[$];
  int edge_q[$];
  localparam logic [7:0] RADR[6] = '{FRPWM_PRESC_ADDR, FRPWM_PORT_ADDR, FRPWM_DUTY_ADDR, FRPWM_PERIOD_ADDR,
    FRPWM_MODE_ADDR, 8'h18};
  localparam logic [31:0] RRST[6] = '{0, 0, 0, 0, 32'h0000_0008, 0};
  // Undriven pin floats to a changing level rather than a stale one
  assign pin_lvl = pin_oe_n ? ext_pin : pin_o;
  always #5 MCLK = ~MCLK;
  frpwm_top dut_u (.MCLK(MCLK), .RST(RST), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .EXT_COUNT_EVENT(ext_evt), .PWM_PIN_I(pin_lvl), .PWM_PIN_O(pin_o), .PWM_PIN_OE_N(pin_oe_n));
  task automatic compare(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : compare
  task automatic stop_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= lanes;
    wb_wdat <= d;
    do @(posedge MCLK); while (ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge MCLK);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd
  always @(posedge MCLK) begin
    ticks <= ticks + 1;
    ext_evt <= 1'($urandom);
    ext_pin <= 1'($urandom);
    if (ack === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0) compare("read", rd_q.pop_front(), rdat);
    if (ticks > 3000) begin
      miscompares++;
      stop_test();
    end
  end
  // Each pin edge is stamped with its count position and level
  always @(negedge MCLK) begin
    if (watch && pin_o !== prev) compare("pin edge", 32'(edge_q.pop_front()), 32'((ticks - base) * 2 + pin_o));
    prev = pin_o;
  end
  initial begin
    void'($urandom(16));
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    wb(1'b1, 8'h18, 32'hFFFF_FFFF);
    foreach (RADR[i]) rd(RADR[i], RRST[i]);
    per = 8 + $urandom % 8;
    // Duty from 2 up keeps the first rise after the start-level sample
    dty = 2 + $urandom % (per - 3);
    dty2 = dty % (per - 1) + 1;
    wb(1'b1, FRPWM_PRESC_ADDR, 32'h0000_0008);
    wb(1'b1, FRPWM_PORT_ADDR, 32'h0000_0002);
    wb(1'b1, FRPWM_PORT_ADDR, 32'h0000_0001);
    wb(1'b1, FRPWM_PERIOD_ADDR, 32'(per));
    rd(FRPWM_PERIOD_ADDR, 32'(per));
    rd(FRPWM_PRESC_ADDR, 32'h0000_0008);
    // Normal, inverted, then fine mode on a halved prescaler clock
    for (int md = 0; md < 3; md++) begin
      inv = (md == 1) ? 1 : 0;
      fine = (md == 2) ? 1 : 0;
      len = (fine == 1) ? ((per >> 1) + 1) * 2 : per + 1;
      if (fine == 1) wb(1'b1, FRPWM_PRESC_ADDR, 32'h0000_0009);
      wb(1'b1, FRPWM_DUTY_ADDR, 32'(dty));
      // Count position 0 is the edge at which the start write lands
      base = ticks + 2;
      wb(1'b1, FRPWM_MODE_ADDR, 32'h0000_002D | 32'(inv << 4) | 32'(fine << 6));
      compare("start level", 32'(inv), 32'(pin_o));
      prev = pin_o;
      for (int c = 0; c < 3; c++) begin
        edge_q.push_back((c * len + (c > 0 ? dty2 : dty)) * 2 + (inv ^ 1));
        edge_q.push_back((c * len + per) * 2 + inv);
      end
      watch = 1'b1;
      repeat ($urandom % (per - 3)) @(posedge MCLK);
      wb(1'b1, FRPWM_DUTY_ADDR, 32'(dty2));
      rd(FRPWM_DUTY_ADDR, 32'(dty2));
      rd(FRPWM_MODE_ADDR, 32'h0000_002D | 32'(inv << 4) | 32'(fine << 6));
      while (ticks - base < 3 * len) @(posedge MCLK);
      watch = 1'b0;
      compare("edges left", 0, 32'(edge_q.size()));
      wb(1'b1, FRPWM_MODE_ADDR, 32'h0000_0008);
    end
    // Preset strobe clears a stopped counter and reads back as zero
    wb(1'b1, FRPWM_MODE_ADDR, 32'h0000_000A);
    rd(FRPWM_STATUS_ADDR, 32'h0000_0000);
    rd(FRPWM_MODE_ADDR, 32'h0000_0008);
    // Byte lanes of a 16-bit compare value land separately
    lanes = 4'h1;
    wb(1'b1, FRPWM_PERIOD_ADDR, 32'h0000_FF5A);
    lanes = 4'h2;
    wb(1'b1, FRPWM_PERIOD_ADDR, 32'h0000_3CFF);
    lanes = 4'hF;
    rd(FRPWM_PERIOD_ADDR, 32'h0000_3C5A);
    stop_test();
  end
endmodule : tb
